// [hw/timer_pkg.sv]
package timer_pkg;

    localparam int          ADDR_W     = 6;
    localparam int          DATA_W     = 32;

    // Register byte offsets, one aligned word each
    localparam logic [5:0]  OFS_CTRL1  = 6'h00;
    localparam logic [5:0]  OFS_CTRL2  = 6'h04;
    localparam logic [5:0]  OFS_FLAGS  = 6'h08;
    localparam logic [5:0]  OFS_IC1H   = 6'h0c;
    localparam logic [5:0]  OFS_IC1L   = 6'h10;
    localparam logic [5:0]  OFS_OC1H   = 6'h14;
    localparam logic [5:0]  OFS_OC1L   = 6'h18;
    localparam logic [5:0]  OFS_OC2H   = 6'h1c;
    localparam logic [5:0]  OFS_OC2L   = 6'h20;
    localparam logic [5:0]  OFS_CNTH   = 6'h24;
    localparam logic [5:0]  OFS_CNTL   = 6'h28;
    localparam logic [5:0]  OFS_ACNTH  = 6'h2c;
    localparam logic [5:0]  OFS_ACNTL  = 6'h30;
    localparam logic [5:0]  OFS_IC2H   = 6'h34;
    localparam logic [5:0]  OFS_IC2L   = 6'h38;
    localparam logic [5:0]  OFS_OC_STEP = 6'h08;

    // ctrl_reg_one fields
    localparam int          C1_CAP_IE  = 7;
    localparam int          C1_CMP_IE  = 6;
    localparam int          C1_OVF_IE  = 5;
    localparam int          C1_FORCE2  = 4;
    localparam int          C1_FORCE1  = 3;
    localparam int          C1_LVL2    = 2;
    localparam int          C1_EDGE1   = 1;
    localparam int          C1_LVL1    = 0;

    // ctrl_reg_two fields
    localparam int          C2_PIN1_EN = 7;
    localparam int          C2_PIN2_EN = 6;
    localparam int          C2_ONE_PLS = 5;
    localparam int          C2_PWM     = 4;
    localparam int          C2_CLK_MSB = 3;
    localparam int          C2_CLK_LSB = 2;
    localparam int          C2_EDGE2   = 1;
    localparam int          C2_EXT_EDGE = 0;

    // Flag vector index; flag_reg shows it in bits 7:3
    localparam int          F_CAP1     = 4;
    localparam int          F_CMP1     = 3;
    localparam int          F_OVF      = 2;
    localparam int          F_CAP2     = 1;
    localparam int          F_CMP2     = 0;
    localparam int          NUM_FLAGS  = 5;

    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [15:0] CMP_RST    = 16'h8000;
    localparam logic [15:0] CNT_RST    = 16'hfffc;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    localparam logic [15:0] ONE_PLS_CAP = 16'hfffd;
    localparam logic [15:0] CAP_RST    = 16'h0000;

    // timer_clk_sel codes and divide factors
    localparam logic [1:0]  CLK_DIV4   = 2'h0;
    localparam logic [1:0]  CLK_DIV2   = 2'h1;
    localparam logic [1:0]  CLK_DIV8   = 2'h2;
    localparam logic [1:0]  CLK_EXT    = 2'h3;
    localparam logic [2:0]  DIV2_LAST  = 3'h1;
    localparam logic [2:0]  DIV4_LAST  = 3'h3;
    localparam logic [2:0]  DIV8_LAST  = 3'h7;

endpackage : timer_pkg

// [hw/timer_prescaler.sv]
`timescale 1ns/1ps
module timer_prescaler
    import timer_pkg::*;
(
    input  wire logic       ref_clk_in,    // Core clock
    input  wire logic       rst_in,        // Sync reset, high
    input  wire logic       clk_en_in,     // Freezes state when low
    input  wire logic       run_in,        // Low while halted
    input  wire logic [1:0] clk_sel_in,    // timer_clk_sel
    input  wire logic       ext_edge_in,   // 1 rising, 0 falling
    input  wire logic       ext_clk_in,    // External clock pin
    output logic            tick_out       // One-cycle count tick
);

    logic [2:0] div_q;
    logic [2:0] last_w;
    logic       ext_s1_q;
    logic       ext_s2_q;
    logic       ext_s3_q;
    logic       ext_tick_w;

    always_comb begin
        case (clk_sel_in)
            CLK_DIV2: last_w = DIV2_LAST;
            CLK_DIV8: last_w = DIV8_LAST;
            default:  last_w = DIV4_LAST;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else if (clk_en_in) begin
            ext_s1_q <= ext_clk_in;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    assign ext_tick_w = ext_edge_in ? (ext_s2_q & ~ext_s3_q) : (~ext_s2_q & ext_s3_q);

    // Divider restarts cleanly if the factor shrinks mid-count
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            div_q <= 3'h0;
        end else if (clk_en_in && run_in && clk_sel_in != CLK_EXT) begin
            div_q <= (div_q >= last_w) ? 3'h0 : div_q + 3'h1;
        end
    end

    // External clock bypasses the divider entirely
    assign tick_out = clk_en_in & run_in &
                      ((clk_sel_in == CLK_EXT) ? ext_tick_w : (div_q >= last_w));

endmodule : timer_prescaler

// [hw/timer_pwm_irq_control.sv]
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module timer_pwm_irq_control
    import timer_pkg::*;
(
    input  wire logic              ref_clk_in,          // 250 MHz core clock
    input  wire logic              rst_in,              // Sync reset, high
    input  wire logic              clk_en_in,           // Freezes all state when low
    input  wire logic [ADDR_W-1:0] avs_address_in,      // Byte address
    input  wire logic              avs_read_in,         // Read request
    input  wire logic              avs_write_in,        // Write request
    input  wire logic [DATA_W-1:0] avs_writedata_in,    // Write data
    input  wire logic [3:0]        avs_byteenable_in,   // Byte lanes
    output logic [DATA_W-1:0]      avs_readdata_out,    // Read data
    output logic                   avs_waitrequest_out, // Stall
    input  wire logic              capture_in1_in,      // Capture pin 1
    input  wire logic              capture_in2_in,      // Capture pin 2
    input  wire logic              ext_clk_in,          // External timer clock pin
    input  wire logic              cpu_halt_in,         // CPU in halt
    input  wire logic              cpu_wait_in,         // CPU in wait
    input  wire logic              cpu_irq_mask_in,     // CPU interrupt mask
    output logic                   wave_out_pin1_out,   // Waveform pin 1 level
    output logic                   wave_pin1_oe_out,    // Pin 1 driven
    output logic                   wave_out_pin2_out,   // Waveform pin 2 level
    output logic                   wave_pin2_oe_out,    // Pin 2 driven
    output logic                   timer_irq_out,       // Shared timer interrupt
    output logic                   wait_wake_out        // Wake CPU from wait
);

    logic [7:0]           ctrl1_q;
    logic [7:0]           ctrl2_q;
    logic [15:0]          oc_q [2];
    logic [1:0]           inhibit_q;
    logic [15:0]          cnt_q;
    logic [15:0]          ic1_q;
    logic [15:0]          ic2_q;
    logic [NUM_FLAGS-1:0] flags_q;
    logic [NUM_FLAGS-1:0] seen_q;
    logic [NUM_FLAGS-1:0] flag_set_w;
    logic [NUM_FLAGS-1:0] flag_clr_w;
    logic                 ack_q;
    logic [DATA_W-1:0]    rdata_q;
    logic [7:0]           rd_mux_w;
    logic [1:0]           cap_s1_q;
    logic [1:0]           cap_s2_q;
    logic [1:0]           cap_s3_q;
    logic [1:0]           edge_w;
    logic [1:0]           armed_q;
    logic [1:0]           cap_fire_w;
    logic                 halt_d_q;
    logic                 wave1_q;
    logic                 wave2_q;
    logic                 req_w;
    logic                 done_w;
    logic                 rd_done_w;
    logic                 wr_done_w;
    logic                 tick_w;
    logic                 pwm_w;
    logic                 one_pls_w;
    logic                 match1_w;
    logic                 match2_w;
    logic                 exit_w;
    logic                 one_pls_trig_w;
    logic                 ovf_w;
    logic                 irq_src_w;
    logic                 cnt_wr_w;

    // Bus slave: one wait cycle, answer on the second edge
    assign req_w               = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req_w & ~ack_q;
    assign done_w              = req_w & ack_q & clk_en_in;
    assign rd_done_w           = done_w & avs_read_in;
    assign wr_done_w           = done_w & avs_write_in & avs_byteenable_in[0];
    assign avs_readdata_out    = rdata_q;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
        end else if (clk_en_in) begin
            ack_q <= req_w & ~ack_q;
        end
    end

    always_comb begin
        case (avs_address_in)
            OFS_CTRL1: rd_mux_w = ctrl1_q;
            OFS_CTRL2: rd_mux_w = ctrl2_q;
            OFS_FLAGS: rd_mux_w = {flags_q, 3'h0};
            OFS_IC1H:  rd_mux_w = ic1_q[15:8];
            OFS_IC1L:  rd_mux_w = ic1_q[7:0];
            OFS_OC1H:  rd_mux_w = oc_q[0][15:8];
            OFS_OC1L:  rd_mux_w = oc_q[0][7:0];
            OFS_OC2H:  rd_mux_w = oc_q[1][15:8];
            OFS_OC2L:  rd_mux_w = oc_q[1][7:0];
            OFS_CNTH:  rd_mux_w = cnt_q[15:8];
            OFS_CNTL:  rd_mux_w = cnt_q[7:0];
            OFS_ACNTH: rd_mux_w = cnt_q[15:8];
            OFS_ACNTL: rd_mux_w = cnt_q[7:0];
            OFS_IC2H:  rd_mux_w = ic2_q[15:8];
            OFS_IC2L:  rd_mux_w = ic2_q[7:0];
            default:   rd_mux_w = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (clk_en_in && avs_read_in && !ack_q) begin
            rdata_q <= {24'h00_0000, rd_mux_w};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ctrl1_q <= CTRL_RST;
            ctrl2_q <= CTRL_RST;
        end else if (wr_done_w) begin
            if (avs_address_in == OFS_CTRL1) begin
                ctrl1_q <= avs_writedata_in[7:0];
            end
            if (avs_address_in == OFS_CTRL2) begin
                ctrl2_q <= avs_writedata_in[7:0];
            end
        end
    end

    // Mode decode
    assign pwm_w     = ctrl2_q[C2_PWM];
    assign one_pls_w = ctrl2_q[C2_ONE_PLS] & ~pwm_w;

    timer_prescaler u_prescaler (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .clk_en_in   (clk_en_in),
        .run_in      (~cpu_halt_in),
        .clk_sel_in  (ctrl2_q[C2_CLK_MSB:C2_CLK_LSB]),
        .ext_edge_in (ctrl2_q[C2_EXT_EDGE]),
        .ext_clk_in  (ext_clk_in),
        .tick_out    (tick_w)
    );

    // Compare registers; high byte write holds the channel off
    for (genvar i = 0; i < 2; i++) begin : g_cmp
        localparam logic [5:0] OFS_H = OFS_OC1H + OFS_OC_STEP * 6'(i);
        localparam logic [5:0] OFS_L = OFS_OC1L + OFS_OC_STEP * 6'(i);
        always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
                oc_q[i]      <= CMP_RST;
                inhibit_q[i] <= 1'b0;
            end else if (wr_done_w && avs_address_in == OFS_H) begin
                oc_q[i][15:8] <= avs_writedata_in[7:0];
                inhibit_q[i]  <= 1'b1;
            end else if (wr_done_w && avs_address_in == OFS_L) begin
                oc_q[i][7:0]  <= avs_writedata_in[7:0];
                inhibit_q[i]  <= 1'b0;
            end
        end
    end

    assign match1_w = tick_w & ~inhibit_q[0] & (cnt_q == oc_q[0]);
    assign match2_w = tick_w & ~inhibit_q[1] & (cnt_q == oc_q[1]);

    // Capture pins: two-stage sync, third stage for edge detect
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cap_s1_q <= 2'h0;
            cap_s2_q <= 2'h0;
            cap_s3_q <= 2'h0;
            halt_d_q <= 1'b0;
        end else if (clk_en_in) begin
            cap_s1_q <= {capture_in2_in, capture_in1_in};
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
            halt_d_q <= cpu_halt_in;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_cap
        logic rise_sel;
        logic live_w;
        assign rise_sel   = (i == 0) ? ctrl1_q[C1_EDGE1] : ctrl2_q[C2_EDGE2];
        // Capture one is cut off from the timer in PWM
        assign live_w     = (i == 0) ? ~pwm_w : 1'b1;
        assign edge_w[i]  = live_w &
                            (rise_sel ? (cap_s2_q[i] & ~cap_s3_q[i])
                                      : (~cap_s2_q[i] & cap_s3_q[i]));
        assign cap_fire_w[i] = (edge_w[i] & ~cpu_halt_in) | (exit_w & armed_q[i]);
        always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
                armed_q[i] <= 1'b0;
            end else if (clk_en_in) begin
                if (exit_w) begin
                    armed_q[i] <= 1'b0;
                end else if (cpu_halt_in && edge_w[i]) begin
                    armed_q[i] <= 1'b1;
                end
            end
        end
    end

    // Leaving halt is by interrupt; a reset wake-up restarts from reset
    assign exit_w         = clk_en_in & halt_d_q & ~cpu_halt_in;
    assign one_pls_trig_w = one_pls_w & cap_fire_w[0];
    assign ovf_w          = tick_w & (cnt_q == CNT_MAX) & ~(pwm_w & match2_w);
    assign cnt_wr_w       = wr_done_w &
                            (avs_address_in == OFS_CNTL || avs_address_in == OFS_ACNTL);

    // Free-running counter; halt stops ticks so it holds its value
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cnt_q <= CNT_RST;
        end else if (clk_en_in) begin
            if (cnt_wr_w || one_pls_trig_w) begin
                cnt_q <= CNT_RST;
            end else if (pwm_w && match2_w) begin
                // Four counts up to wrap plus one at the match
                cnt_q <= CNT_RST;
            end else if (tick_w) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ic1_q <= CAP_RST;
            ic2_q <= CAP_RST;
        end else if (clk_en_in) begin
            if (one_pls_trig_w) begin
                ic1_q <= ONE_PLS_CAP;
            end else if (cap_fire_w[0]) begin
                ic1_q <= cnt_q;
            end
            if (cap_fire_w[1]) begin
                ic2_q <= cnt_q;
            end
        end
    end

    // Flag events; compare flags held off in PWM, compare one in one-pulse
    assign flag_set_w[F_CAP1] = cap_fire_w[0] | (pwm_w & match2_w);
    assign flag_set_w[F_CMP1] = match1_w & ~pwm_w & ~one_pls_w;
    assign flag_set_w[F_OVF]  = ovf_w;
    assign flag_set_w[F_CAP2] = cap_fire_w[1];
    assign flag_set_w[F_CMP2] = match2_w & ~pwm_w;

    assign flag_clr_w[F_CAP1] = done_w & (avs_address_in == OFS_IC1L);
    assign flag_clr_w[F_CMP1] = done_w & (avs_address_in == OFS_OC1L);
    assign flag_clr_w[F_OVF]  = done_w & (avs_address_in == OFS_CNTL);
    assign flag_clr_w[F_CAP2] = done_w & (avs_address_in == OFS_IC2L);
    assign flag_clr_w[F_CMP2] = done_w & (avs_address_in == OFS_OC2L);

    // Two-step clear; a new event in the clearing cycle wins
    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
                flags_q[i] <= 1'b0;
                seen_q[i]  <= 1'b0;
            end else if (clk_en_in) begin
                if (flag_set_w[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (flag_clr_w[i] && seen_q[i]) begin
                    flags_q[i] <= 1'b0;
                end
                if (rd_done_w && avs_address_in == OFS_FLAGS) begin
                    seen_q[i] <= flags_q[i];
                end else if (flag_clr_w[i]) begin
                    seen_q[i] <= 1'b0;
                end
            end
        end
    end

    // Waveform pin 1: PWM, one-pulse, forced or plain compare
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wave1_q <= 1'b0;
        end else if (clk_en_in) begin
            if (pwm_w) begin
                // Equal levels leave the pin constant
                if (match2_w) begin
                    wave1_q <= ctrl1_q[C1_LVL2];
                end else if (match1_w) begin
                    wave1_q <= ctrl1_q[C1_LVL1];
                end
            end else if (one_pls_w) begin
                if (one_pls_trig_w) begin
                    wave1_q <= ctrl1_q[C1_LVL2];
                end else if (match1_w) begin
                    wave1_q <= ctrl1_q[C1_LVL1];
                end
            end else if (ctrl1_q[C1_FORCE1] || match1_w) begin
                wave1_q <= ctrl1_q[C1_LVL1];
            end
        end
    end

    // Level two belongs to pin one in PWM and one-pulse
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wave2_q <= 1'b0;
        end else if (clk_en_in && !pwm_w && !one_pls_w) begin
            if (ctrl1_q[C1_FORCE2] || match2_w) begin
                wave2_q <= ctrl1_q[C1_LVL2];
            end
        end
    end

    assign wave_out_pin1_out = wave1_q;
    assign wave_pin1_oe_out  = ctrl2_q[C2_PIN1_EN];
    assign wave_out_pin2_out = wave2_q;
    assign wave_pin2_oe_out  = ctrl2_q[C2_PIN2_EN];

    assign irq_src_w = (ctrl1_q[C1_CAP_IE] & (flags_q[F_CAP1] | flags_q[F_CAP2]))
                     | (ctrl1_q[C1_CMP_IE] & (flags_q[F_CMP1] | flags_q[F_CMP2]))
                     | (ctrl1_q[C1_OVF_IE] & flags_q[F_OVF]);
    assign timer_irq_out = irq_src_w & ~cpu_irq_mask_in;
    // Wait never gates the timer; halt wake-up is not ours to give
    assign wait_wake_out = timer_irq_out & cpu_wait_in & ~cpu_halt_in;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_flags_read_cap1;
        rd_done_w && avs_address_in == OFS_FLAGS && flags_q[F_CAP1];
    endsequence
    sequence s_cap1_low_access;
        flag_clr_w[F_CAP1] && !flag_set_w[F_CAP1];
    endsequence

    a_pwm_period_reload: assert property (
        pwm_w && match2_w && !cnt_wr_w |=> cnt_q == CNT_RST)
        else $error("PWM period match did not reload counter");
    a_pwm_level_one: assert property (
        pwm_w && match1_w && !match2_w |=> wave1_q == $past(ctrl1_q[C1_LVL1]))
        else $error("Pulse match did not drive level one");
    a_pwm_level_two: assert property (
        pwm_w && match2_w |=> wave1_q == $past(ctrl1_q[C1_LVL2]))
        else $error("Period match did not drive level two");
    a_pwm_no_cmp_flag: assert property (
        pwm_w && !flags_q[F_CMP1] && !flags_q[F_CMP2] |=> !flags_q[F_CMP1] && !flags_q[F_CMP2])
        else $error("Compare flag set in PWM");
    a_pwm_cap1_flag: assert property (
        pwm_w && match2_w |=> flags_q[F_CAP1])
        else $error("PWM period match missed capture flag one");
    a_cmp_inhibit_hold: assert property (
        inhibit_q[0] && !flags_q[F_CMP1] |=> !flags_q[F_CMP1])
        else $error("Inhibited compare set its flag");
    a_halt_count_hold: assert property (
        cpu_halt_in && !wr_done_w |=> $stable(cnt_q))
        else $error("Counter moved during halt");
    a_irq_mask_gate: assert property (
        cpu_irq_mask_in || !(ctrl1_q[C1_CAP_IE] | ctrl1_q[C1_CMP_IE] | ctrl1_q[C1_OVF_IE])
        |-> !timer_irq_out)
        else $error("Interrupt raised while masked or disabled");
    a_no_halt_wake: assert property (
        cpu_halt_in |-> !wait_wake_out)
        else $error("Timer event woke CPU from halt");
    a_cap1_two_step: assert property (
        s_flags_read_cap1 ##[1:40] s_cap1_low_access |=> !flags_q[F_CAP1])
        else $error("Capture flag one not cleared by sequence");
    a_pwm_cap1_cut: assert property (
        pwm_w && !match2_w && !flags_q[F_CAP1] |=> !flags_q[F_CAP1])
        else $error("Capture one pin reached timer in PWM");

endmodule : timer_pwm_irq_control

// [bench/cap_pin_model.sv]
`timescale 1ns/1ps
module cap_pin_model (
    input  wire logic       ref_clk_in, // Bench clock
    output logic      [1:0] cap_out     // Capture pins 2 and 1
);
    logic [5:0] n;
    initial {n, cap_out} = 8'h00;
    always @(posedge ref_clk_in) begin
        n <= n + 6'h01;
        if (n == 6'h3f) cap_out <= ~cap_out;
    end
endmodule : cap_pin_model

// [bench/timer_pwm_irq_control_tb_top.sv]
`timescale 1ns/1ps
module timer_pwm_irq_control_tb_top;
    import timer_pkg::*;
    logic        ref_clk_in, rst_in, clk_en_in, avs_read_in, avs_write_in, ext_clk_in;
    logic        cpu_halt_in, cpu_wait_in, cpu_irq_mask_in, capture_in1_in, capture_in2_in;
    logic        avs_waitrequest_out, timer_irq_out, wait_wake_out, wave_pin1_oe_out;
    logic        wave_out_pin1_out, wave_out_pin2_out, wave_pin2_oe_out;
    logic [5:0]  avs_address_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_writedata_in, avs_readdata_out;
    logic [7:0]  q;
    logic [3:0]  pins;
    assign pins = {wave_pin1_oe_out, wave_pin2_oe_out, wave_out_pin1_out, wave_out_pin2_out};
    int          fail_count, n_tests;
    cap_pin_model pm (.ref_clk_in, .cap_out({capture_in2_in, capture_in1_in}));
    timer_pwm_irq_control dut (.*);
    initial forever #2 ref_clk_in = ~ref_clk_in;
    task automatic check(input string nm, input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp) fail_count++;
        if (got !== exp) $display("wrong value %s expected %h seen %h", nm, exp, got);
    endtask : check
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        {avs_address_in, avs_writedata_in} <= {a, 24'h00_0000, d};
        {avs_write_in, avs_read_in} <= {wr, ~wr};
        // Look at waitrequest mid-cycle, so the completing edge is known beforehand
        @(negedge ref_clk_in);
        for (int n = 0; n < 40 && avs_waitrequest_out !== 1'b0; n++) @(negedge ref_clk_in);
        if (avs_waitrequest_out !== 1'b0) fail_count++;
        q = avs_readdata_out[7:0];
        @(posedge ref_clk_in);
        {avs_write_in, avs_read_in} <= 2'h0;
        @(posedge ref_clk_in);
    endtask : bus
    task automatic t_pwm;
        logic [5:0] pa[7] = '{OFS_CTRL1, OFS_CTRL2, OFS_OC1H, OFS_OC1L, OFS_OC2H, OFS_OC2L,
                              OFS_CNTL};
        logic [7:0] pd[7] = '{8'h81, 8'hb6, 8'h00, 8'h02, 8'h00, 8'h06, 8'h00};
        time        t;
        bus(1'b0, OFS_CTRL1, 8'h00);
        check("ctrl1", 16'(q), 16'h0000);
        foreach (pa[i]) bus(1'b1, pa[i], pd[i]);
        @(posedge wave_out_pin1_out) t = $time;
        @(negedge wave_out_pin1_out) t = $time - t;
        check("high", 16'(t / 4), 16'h0008);
        t = $time;
        @(posedge wave_out_pin1_out) t = $time - t;
        check("low", 16'(t / 4), 16'h000e);
        repeat (140) @(posedge ref_clk_in);
        bus(1'b0, OFS_FLAGS, 8'h00);
        check("flags", 16'({q[7], q[6], q[4], q[3]}), 16'h000a);
        {cpu_irq_mask_in, cpu_wait_in} <= 2'h1;
        @(negedge ref_clk_in);
        check("irq", 16'({timer_irq_out, wait_wake_out}), 16'h0003);
        @(posedge ref_clk_in);
        cpu_halt_in <= 1'b1;
        @(negedge ref_clk_in);
        check("halt wake", 16'({timer_irq_out, wait_wake_out}), 16'h0002);
        @(posedge ref_clk_in);
        cpu_irq_mask_in <= 1'b1;
        @(negedge ref_clk_in);
        check("halted", 16'({timer_irq_out, wait_wake_out}), 16'h0000);
        @(posedge ref_clk_in);
        cpu_halt_in <= 1'b0;
        $display("pwm done");
    endtask : t_pwm
    task automatic t_force;
        bus(1'b1, OFS_CTRL2, 8'hc0);
        // Capture one flag still set from PWM; clear it well before the next pin edge
        bus(1'b0, OFS_FLAGS, 8'h00);
        check("cap1 set", 16'(q[7]), 16'h0001);
        bus(1'b0, OFS_IC1L, 8'h00);
        bus(1'b0, OFS_FLAGS, 8'h00);
        check("cap1 cleared", 16'(q[7]), 16'h0000);
        bus(1'b1, OFS_CTRL1, 8'h1d);
        @(posedge ref_clk_in);
        check("forced", 16'(pins), 16'h000f);
        bus(1'b1, OFS_CTRL1, 8'h18);
        @(posedge ref_clk_in);
        check("forced low", 16'(pins), 16'h000c);
        $display("force done");
    endtask : t_force
    task automatic give_verdict;
        $display("%0d checks %0d wrong", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    initial begin
        {ref_clk_in, rst_in, cpu_irq_mask_in, clk_en_in, avs_byteenable_in} = 8'h71;
        {avs_read_in, avs_write_in, ext_clk_in, cpu_halt_in, cpu_wait_in} = '0;
        {avs_address_in, avs_writedata_in, fail_count, n_tests} = '0;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_pwm();
        t_force();
        give_verdict();
    end
    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end
endmodule : timer_pwm_irq_control_tb_top
